// ---- cbl_chan_model.sv ----
// channel-side model: presents commands at initial selection
`timescale 1ns/10ps
`default_nettype none
module cbl_chan_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic [7:0] i_code,
    input  wire logic       i_perr,
    input  wire logic       i_tio,
    output logic            o_cmd_valid,
    output logic      [7:0] o_cmd,
    output logic            o_cmd_perr,
    output logic            o_test_io
);
    // --------------------
    // command presentation
    // --------------------
    // code toggles while no command is offered
    always_ff @(posedge i_clk) begin
        o_cmd_valid <= i_go & ~i_rst;
        o_cmd       <= i_rst ? 8'h00 : (i_go ? i_code : ~o_cmd);
        o_cmd_perr  <= i_go & i_perr;
        o_test_io   <= i_go & i_tio;
    end
endmodule
`default_nettype wire

// ---- cbl_char_buf.sv ----
// four-slot character buffer with running count and data-present flag
`timescale 1ns/10ps
`default_nettype none
module cbl_char_buf (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_line_wr,
    input  wire logic [7:0] i_line_data,
    input  wire logic       i_take,
    input  wire logic       i_ch_wr,
    input  wire logic [7:0] i_ch_data,
    input  wire logic [1:0] i_sel,
    input  wire logic       i_clr,
    output logic      [7:0] o_sel_data,
    output logic      [7:0] o_cnt_data,
    output logic      [1:0] o_count,
    output logic            o_present,
    output logic            o_wrap
);
    logic [7:0] slot_r [cbl_pkg::NSLOT];
    logic [1:0] count_r;
    logic       present_r;
    wire        advance = i_line_wr || i_take;

    // ---------------------------------------------
    // slots
    // ---------------------------------------------
    for (genvar g = 0; g < cbl_pkg::NSLOT; g++) begin : g_slot
        always_ff @(posedge i_clk) begin
            if (i_rst)
                slot_r[g] <= '0;
            else if (i_line_wr && count_r == 2'(g))
                slot_r[g] <= i_line_data;
            else if (i_ch_wr && i_sel == 2'(g))
                slot_r[g] <= i_ch_data;
        end
    end

    // ---------------------------------------------
    // count and data flag
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_r   <= '0;
            present_r <= 1'b0;
        end else begin
            if (advance)
                count_r <= count_r + 2'h1;
            if (i_line_wr || i_ch_wr)
                present_r <= 1'b1;
            else if (i_clr)
                present_r <= 1'b0;
        end
    end

    assign o_sel_data = slot_r[i_sel];
    assign o_cnt_data = slot_r[count_r];
    assign o_count    = count_r;
    assign o_present  = present_r;
    assign o_wrap     = advance && count_r == 2'(cbl_pkg::NSLOT - 1);
endmodule
`default_nettype wire

// ---- cbl_pkg.sv ----
// package: constants, types and carriers for the channel status byte logic
package cbl_pkg;
    localparam int unsigned NSLOT = 4;
    localparam int unsigned NSET  = 2;

    // ---------------------------------------------
    // register offsets
    // ---------------------------------------------
    localparam logic [3:0] A_CTRL  = 4'h0;
    localparam logic [3:0] A_MIDCH = 4'h1;
    localparam logic [3:0] A_LCW1  = 4'h2;
    localparam logic [3:0] A_DATA  = 4'h3;
    localparam logic [3:0] A_ACK   = 4'h4;
    localparam logic [3:0] A_STAT  = 4'h5;
    localparam logic [3:0] A_INFO  = 4'h6;

    // ---------------------------------------------
    // field positions and reset values
    // ---------------------------------------------
    localparam int unsigned CT_TYPE_LO  = 0;
    localparam int unsigned CT_SYNC     = 2;
    localparam int unsigned CT_BURST    = 3;
    localparam int unsigned CT_SWITCHED = 4;
    localparam int unsigned CT_EXPORT   = 5;
    localparam int unsigned ACK_DS      = 0;
    localparam int unsigned ACK_END     = 1;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [2:0] LCW1_RST     = 3'h0;

    // ---------------------------------------------
    // status byte bits and patterns
    // ---------------------------------------------
    localparam int unsigned SB_ATTN = 0;
    localparam int unsigned SB_SM   = 1;
    localparam int unsigned SB_CUE  = 2;
    localparam int unsigned SB_BUSY = 3;
    localparam int unsigned SB_CE   = 4;
    localparam int unsigned SB_DE   = 5;
    localparam int unsigned SB_UC   = 6;
    localparam int unsigned SB_UE   = 7;
    localparam logic [7:0] S_ZERO   = 8'h00;
    localparam logic [7:0] S_BUSY   = 8'h0e;
    localparam logic [7:0] S_SM     = 8'h02;
    localparam logic [7:0] S_UC     = 8'h40;
    localparam logic [7:0] S_CEDE   = 8'h30;

    // ---------------------------------------------
    // terminal types, commands, characters
    // ---------------------------------------------
    localparam logic [1:0] TT_TC1 = 2'h0;
    localparam logic [1:0] TT_TC2 = 2'h1;
    localparam logic [1:0] TT_TG2 = 2'h2;
    localparam logic [1:0] TT_TG1 = 2'h3;
    localparam logic [1:0] C_WR_LOW  = 2'h1;
    localparam logic [7:0] C_WRITE   = 8'h01;
    localparam logic [7:0] C_READ    = 8'h02;
    localparam logic [7:0] C_SENSE   = 8'h04;
    localparam logic [7:0] C_PREPARE = 8'h06;
    localparam logic [7:0] C_POLL    = 8'h09;
    localparam logic [7:0] C_INHIBIT = 8'h0a;
    localparam logic [7:0] C_SEARCH  = 8'h0e;
    localparam logic [7:0] C_ADRPREP = 8'h16;
    localparam logic [7:0] C_ENABLE  = 8'h27;
    localparam logic [7:0] C_DIAL    = 8'h29;
    localparam logic [7:0] C_DISABLE = 8'h2f;
    localparam logic [7:0] CH_EOT    = 8'h04;
    localparam logic [7:0] CH_FIGS   = 8'h1b;
    localparam logic [7:0] CH_LTRS   = 8'h1f;
    localparam logic [7:0] CH_H      = 8'h14;
    localparam logic [7:0] CH_N      = 8'h4e;

    typedef struct packed {
        logic       rx_valid;
        logic [7:0] rx_char;
        logic       start_bit;
        logic       halt;
        logic       stop;
        logic       dset_conn;
        logic       enable_on;
        logic       dial_done;
        logic       poll_pos;
        logic       sync_timeout;
        logic       poll_addr;
        logic       ctl_mode;
        logic       search_bad;
        logic       tx_take;
    } cbl_evt_t;

    typedef enum logic [1:0] {L_IDLE, L_RUN, L_END} cbl_state_t;
endpackage

// ---- cbl_status_unit.sv ----
// status byte generation and character buffering for one communication line
//
// Overview of operation
// - single mode serves one byte per service request; burst mode serves four.
// - able to attempt the command: initial status is all zeros.
// - busy control unit: initial status is modifier, control unit end and busy.
// - command parity error or invalid code: initial status is unit check.
// - test I/O gives modifier alone when idle, busy status when busy.
// - attention bit is never set.
// - modifier on poll response; sync lines add timeout and, on address prepare, polling address.
// - ending status always carries channel end with device end.
// - ending status unit check is set whenever any sense bit is on.
// - unusual endings add unit exception to channel and device end.
// - type II telegraph read ends unusual on end-of-transmission char.
// - type I telegraph read ends unusual on figures, middle char, letters.
// - type I control inhibit ends unusual on N in control mode.
// - search ends unusual on invalid command or figures-letters sequence.
// - write-type command accepted while line receiving ends unusual at once.
// - prepare halted before a valid start bit ends unusual.
// - enable halted before connection or enable latch ends unusual.
// - dial halted before all digits sent ends unusual.
// - four byte slots, channel slot chosen by control word character address.
// - two-bit count gives next slot for received and transmitted chars.
// - data flag is on while data is stored in the buffer.
// - second identical buffer set is used only with sync feature on.
// - data service flag raised when four chars (burst) or one char (single) are needed or ready.
// - ending flag raised while ending status waits for the channel.
`timescale 1ns/10ps
`default_nettype none
module cbl_status_unit (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [3:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [7:0]       o_rdata,
    input  wire logic             i_cmd_valid,
    input  wire logic [7:0]       i_cmd,
    input  wire logic             i_cmd_perr,
    input  wire logic             i_test_io,
    input  wire logic [7:0]       i_sense,
    input  wire cbl_pkg::cbl_evt_t i_evt,
    output logic                  o_init_valid,
    output logic      [7:0]       o_init_status,
    output logic                  o_end_flag,
    output logic      [7:0]       o_end_status,
    output logic                  o_data_service,
    output logic                  o_tx_valid,
    output logic      [7:0]       o_tx_char
);
    cbl_pkg::cbl_state_t state_r;
    logic [7:0] ctrl_r;
    logic [7:0] midch_r;
    logic [2:0] lcw1_r;
    logic [7:0] cmd_r;
    logic       wr_recv_r;
    logic       receiving_r;
    logic       start_seen_r;
    logic       conn_seen_r;
    logic       en_seen_r;
    logic       dial_seen_r;
    logic       sm_r;
    logic [7:0] prev1_r;
    logic [7:0] prev2_r;

    // ---------------------------------------------
    // register decode
    // ---------------------------------------------
    wire wr_ctrl  = i_wr && i_addr == cbl_pkg::A_CTRL;
    wire wr_midch = i_wr && i_addr == cbl_pkg::A_MIDCH;
    wire wr_lcw1  = i_wr && i_addr == cbl_pkg::A_LCW1;
    wire wr_data  = i_wr && i_addr == cbl_pkg::A_DATA;
    wire wr_ack   = i_wr && i_addr == cbl_pkg::A_ACK;
    wire rd_data  = i_rd && i_addr == cbl_pkg::A_DATA;
    wire ack_ds   = wr_ack && i_wdata[cbl_pkg::ACK_DS];
    wire ack_end  = wr_ack && i_wdata[cbl_pkg::ACK_END];

    wire [1:0] term     = ctrl_r[cbl_pkg::CT_TYPE_LO +: 2];
    wire       sync_on  = ctrl_r[cbl_pkg::CT_SYNC];
    wire       burst    = ctrl_r[cbl_pkg::CT_BURST];
    wire       switched = ctrl_r[cbl_pkg::CT_SWITCHED];
    wire       export_c = ctrl_r[cbl_pkg::CT_EXPORT];
    wire       tc1      = term == cbl_pkg::TT_TC1;
    wire       tg1      = term == cbl_pkg::TT_TG1;
    wire       tg2      = term == cbl_pkg::TT_TG2;

    // ---------------------------------------------
    // initial selection
    // ---------------------------------------------
    wire busy     = state_r != cbl_pkg::L_IDLE;
    wire code_ok  = i_cmd == cbl_pkg::C_WRITE || i_cmd == cbl_pkg::C_READ
                 || i_cmd == cbl_pkg::C_SENSE || i_cmd == cbl_pkg::C_PREPARE
                 || i_cmd == cbl_pkg::C_POLL || i_cmd == cbl_pkg::C_INHIBIT
                 || i_cmd == cbl_pkg::C_SEARCH || i_cmd == cbl_pkg::C_ADRPREP
                 || i_cmd == cbl_pkg::C_ENABLE || i_cmd == cbl_pkg::C_DIAL
                 || i_cmd == cbl_pkg::C_DISABLE;
    wire cmd_bad  = i_cmd_perr || !code_ok;
    wire accept   = i_cmd_valid && !busy && !i_test_io && !cmd_bad;
    wire new_wr   = i_cmd[1:0] == cbl_pkg::C_WR_LOW;
    wire [7:0] init_stat = busy ? cbl_pkg::S_BUSY
                         : i_test_io ? cbl_pkg::S_SM
                         : cmd_bad ? cbl_pkg::S_UC
                         : cbl_pkg::S_ZERO;

    // ---------------------------------------------
    // ending conditions
    // ---------------------------------------------
    wire running = state_r == cbl_pkg::L_RUN;
    wire is_wr   = cmd_r[1:0] == cbl_pkg::C_WR_LOW;
    wire rx_ok   = running && i_evt.rx_valid;
    wire [7:0] mid_ch = export_c ? midch_r : cbl_pkg::CH_H;
    wire fhl     = rx_ok && prev2_r == cbl_pkg::CH_FIGS && prev1_r == mid_ch
                && i_evt.rx_char == cbl_pkg::CH_LTRS;
    wire ue_read = cmd_r == cbl_pkg::C_READ
                && ((tg2 && rx_ok && i_evt.rx_char == cbl_pkg::CH_EOT) || (tg1 && fhl));
    wire ue_inh  = cmd_r == cbl_pkg::C_INHIBIT && tc1 && i_evt.ctl_mode
                && rx_ok && i_evt.rx_char == cbl_pkg::CH_N;
    wire ue_srch = cmd_r == cbl_pkg::C_SEARCH && running
                && (((tc1 || tg2) && i_evt.search_bad) || (tg1 && fhl));
    wire halt    = running && i_evt.halt;
    wire prep_nb = cmd_r == cbl_pkg::C_PREPARE && !(start_seen_r || i_evt.start_bit);
    wire enab_nc = cmd_r == cbl_pkg::C_ENABLE
                && (switched ? !(conn_seen_r || i_evt.dset_conn)
                             : !(en_seen_r || i_evt.enable_on));
    wire dial_nd = cmd_r == cbl_pkg::C_DIAL && !(dial_seen_r || i_evt.dial_done);
    wire ue_halt = halt && (prep_nb || enab_nc || dial_nd);
    wire ue_now  = (running && wr_recv_r) || ue_read || ue_inh || ue_srch || ue_halt;
    wire end_now = ue_now || halt || (running && i_evt.stop);
    wire sm_now  = sm_r || (running && (i_evt.poll_pos || (sync_on && (i_evt.sync_timeout
                || (cmd_r == cbl_pkg::C_ADRPREP && i_evt.poll_addr)))));
    wire [7:0] end_stat;
    assign end_stat[cbl_pkg::SB_ATTN] = 1'b0;
    assign end_stat[cbl_pkg::SB_SM]   = sm_now;
    assign end_stat[cbl_pkg::SB_CUE]  = 1'b0;
    assign end_stat[cbl_pkg::SB_BUSY] = 1'b0;
    assign end_stat[cbl_pkg::SB_CE]   = 1'b1;
    assign end_stat[cbl_pkg::SB_DE]   = 1'b1;
    assign end_stat[cbl_pkg::SB_UC]   = |i_sense;
    assign end_stat[cbl_pkg::SB_UE]   = ue_now;

    // ---------------------------------------------
    // buffer sets
    // ---------------------------------------------
    wire       set_sel = sync_on;
    wire       line_wr = rx_ok && !is_wr;
    wire       take    = running && is_wr && i_evt.tx_take;
    logic [7:0] sel_data [cbl_pkg::NSET];
    logic [7:0] cnt_data [cbl_pkg::NSET];
    logic [1:0] count    [cbl_pkg::NSET];
    logic       present  [cbl_pkg::NSET];
    logic       wrap     [cbl_pkg::NSET];

    for (genvar s = 0; s < cbl_pkg::NSET; s++) begin : g_set
        wire act = set_sel == 1'(s);
        cbl_char_buf u_buf (
            .i_clk       (i_clk),
            .i_rst       (i_rst),
            .i_line_wr   (act && line_wr),
            .i_line_data (i_evt.rx_char),
            .i_take      (act && take),
            .i_ch_wr     (act && wr_data),
            .i_ch_data   (i_wdata),
            .i_sel       (lcw1_r[1:0]),
            .i_clr       (act && ack_ds),
            .o_sel_data  (sel_data[s]),
            .o_cnt_data  (cnt_data[s]),
            .o_count     (count[s]),
            .o_present   (present[s]),
            .o_wrap      (wrap[s])
        );
    end

    wire advance = line_wr || take;
    wire ds_set  = burst ? wrap[set_sel] : advance;

    // ---------------------------------------------
    // read mux
    // ---------------------------------------------
    wire [7:0] info = {2'h0, receiving_r, o_end_flag, o_data_service,
                       present[set_sel], count[set_sel]};
    wire [7:0] rd_mux = i_addr == cbl_pkg::A_CTRL  ? ctrl_r
                      : i_addr == cbl_pkg::A_MIDCH ? midch_r
                      : i_addr == cbl_pkg::A_LCW1  ? {5'h00, lcw1_r}
                      : rd_data                    ? sel_data[set_sel]
                      : i_addr == cbl_pkg::A_STAT  ? o_end_status
                      : i_addr == cbl_pkg::A_INFO  ? info
                      : 8'h00;

    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r  <= cbl_pkg::CTRL_RST;
            midch_r <= cbl_pkg::CH_H;
            lcw1_r  <= cbl_pkg::LCW1_RST;
            o_rdata <= 8'h00;
        end else begin
            if (wr_ctrl)
                ctrl_r <= i_wdata;
            if (wr_midch)
                midch_r <= i_wdata;
            if (wr_lcw1)
                lcw1_r <= i_wdata[2:0];
            if (i_rd)
                o_rdata <= rd_mux;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_init_valid  <= 1'b0;
            o_init_status <= 8'h00;
        end else begin
            o_init_valid <= i_cmd_valid;
            if (i_cmd_valid)
                o_init_status <= init_stat;
        end
    end

    // ---------------------------------------------
    // command sequence
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r      <= cbl_pkg::L_IDLE;
            cmd_r        <= 8'h00;
            wr_recv_r    <= 1'b0;
            o_end_flag   <= 1'b0;
            o_end_status <= 8'h00;
        end else begin
            case (state_r)
                cbl_pkg::L_IDLE: begin
                    if (accept) begin
                        state_r   <= cbl_pkg::L_RUN;
                        cmd_r     <= i_cmd;
                        wr_recv_r <= new_wr && receiving_r;
                    end
                end
                cbl_pkg::L_RUN: begin
                    if (end_now) begin
                        state_r      <= cbl_pkg::L_END;
                        o_end_flag   <= 1'b1;
                        o_end_status <= end_stat;
                        wr_recv_r    <= 1'b0;
                    end
                end
                cbl_pkg::L_END: begin
                    if (ack_end) begin
                        state_r    <= cbl_pkg::L_IDLE;
                        o_end_flag <= 1'b0;
                    end
                end
                default: state_r <= cbl_pkg::L_IDLE;
            endcase
        end
    end

    // ---------------------------------------------
    // line tracking
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            receiving_r  <= 1'b0;
            start_seen_r <= 1'b0;
            conn_seen_r  <= 1'b0;
            en_seen_r    <= 1'b0;
            dial_seen_r  <= 1'b0;
            sm_r         <= 1'b0;
            prev1_r      <= 8'h00;
            prev2_r      <= 8'h00;
        end else begin
            if (i_evt.start_bit)
                receiving_r <= 1'b1;
            else if (running && end_now && !is_wr)
                receiving_r <= 1'b0;
            if (accept) begin
                start_seen_r <= 1'b0;
                conn_seen_r  <= 1'b0;
                en_seen_r    <= 1'b0;
                dial_seen_r  <= 1'b0;
                sm_r         <= 1'b0;
            end else if (running) begin
                start_seen_r <= start_seen_r || i_evt.start_bit;
                conn_seen_r  <= conn_seen_r || i_evt.dset_conn;
                en_seen_r    <= en_seen_r || i_evt.enable_on;
                dial_seen_r  <= dial_seen_r || i_evt.dial_done;
                sm_r         <= sm_now;
            end
            if (rx_ok) begin
                prev1_r <= i_evt.rx_char;
                prev2_r <= prev1_r;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data_service <= 1'b0;
            o_tx_valid     <= 1'b0;
            o_tx_char      <= 8'h00;
        end else begin
            if (ds_set)
                o_data_service <= 1'b1;
            else if (ack_ds)
                o_data_service <= 1'b0;
            o_tx_valid <= take;
            if (take)
                o_tx_char <= cnt_data[set_sel];
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_attn_never: assert property (!o_init_status[cbl_pkg::SB_ATTN] && !o_end_status[cbl_pkg::SB_ATTN])
        else $error("attention bit set");
    a_busy_init: assert property (i_cmd_valid && busy |=> o_init_valid && o_init_status == 8'h0e)
        else $error("busy initial status wrong");
    a_zero_init: assert property (accept |=> o_init_status == 8'h00 ##1 state_r != cbl_pkg::L_IDLE)
        else $error("accepted command not all zeros");
    a_bad_cmd: assert property (i_cmd_valid && !busy && !i_test_io && i_cmd_perr |=> o_init_status == 8'h40)
        else $error("parity error without unit check");
    a_tio_idle: assert property (i_cmd_valid && i_test_io && !busy |=> o_init_status == 8'h02 && !busy)
        else $error("test io status wrong");
    a_end_cede: assert property ($rose(o_end_flag) |-> o_end_status[5:4] == 2'h3)
        else $error("end without channel and device end");
    a_wr_recv: assert property (accept && new_wr && receiving_r |-> ##2 o_end_flag && o_end_status[7])
        else $error("write while receiving not unusual");
    a_sense_uc: assert property ($rose(o_end_flag) |-> o_end_status[6] == ($past(i_sense) != 8'h00))
        else $error("unit check not tied to sense");
    a_wrap_ds: assert property (burst && wrap[set_sel] |=> o_data_service)
        else $error("wrap without data service");
    a_halt_prep: assert property (halt && cmd_r == cbl_pkg::C_PREPARE && !start_seen_r && !i_evt.start_bit
        |=> o_end_flag && o_end_status[7])
        else $error("halted prepare not unusual");
endmodule
`default_nettype wire

// ---- tb.sv ----
// testbench for the channel status byte logic
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [7:0] ctrl, cmd; logic [23:0] ch; logic [11:0] e0; logic [20:0] e1; logic [7:0] es;
    } cbl_row_t;
    logic              clk, rst, wr, rd, go, perr, tio, cmd_valid, cmd_perr, test_io, init_valid, end_flag;
    logic [3:0]        addr;
    logic              tx_valid, ds;
    logic [7:0]        wdata, code, sense, cmd, rdata, init_status, end_status, tx_char;
    cbl_pkg::cbl_evt_t evt;
    int                err_count, checks, i, j;
    cbl_row_t          rows [15];
    cbl_chan_model chan_u (.i_clk(clk), .i_rst(rst), .i_go(go), .i_code(code), .i_perr(perr), .i_tio(tio),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_cmd_perr(cmd_perr), .o_test_io(test_io));
    cbl_status_unit dut_u (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_perr(cmd_perr), .i_test_io(test_io),
        .i_sense(sense), .i_evt(evt), .o_init_valid(init_valid), .o_init_status(init_status),
        .o_end_flag(end_flag), .o_end_status(end_status), .o_data_service(ds), .o_tx_valid(tx_valid),
        .o_tx_char(tx_char));
    // ------------
    // shared tasks
    // ------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rreg(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task pulse(input logic [20:0] e);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        @(posedge clk);
    endtask
    task issue(input logic [7:0] c, input logic p, input logic t, input logic [7:0] exp);
        code <= c;
        perr <= p;
        tio <= t;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        chk({7'h00, init_valid}, 8'h01);
        chk(init_status, exp);
    endtask
    task wait_end(input logic [7:0] exp);
        int n;
        #1;
        for (n = 0; n < 40 && end_flag !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 40) begin
            err_count++;
            summarize();
        end else begin
            chk(end_status, exp);
            wreg(cbl_pkg::A_ACK, 8'h02);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // -------------
    // main sequence
    // -------------
    initial begin
        rst = 1'b1;
        {wr, rd, go, perr, tio, addr, wdata, code, sense, evt} = '0;
        err_count = 0;
        checks = 0;
        rows = '{'{8'h02, 8'h02, 24'h0, 12'h0, 21'h104000, 8'hb0}, '{8'h03, 8'h02, 24'h1b141f, 12'h0, 21'h0, 8'hb0},
            '{8'h00, 8'h0a, 24'h0, 12'h0, 21'h14e004, 8'hb0}, '{8'h00, 8'h0e, 24'h0, 12'h0, 21'h2, 8'hb0},
            '{8'h03, 8'h0e, 24'h1b141f, 12'h0, 21'h0, 8'hb0}, '{8'h02, 8'h06, 24'h0, 12'h0, 21'h400, 8'hb0},
            '{8'h02, 8'h06, 24'h0, 12'h800, 21'h400, 8'h30}, '{8'h12, 8'h27, 24'h0, 12'h0, 21'h400, 8'hb0},
            '{8'h03, 8'h27, 24'h0, 12'h0, 21'h400, 8'hb0}, '{8'h02, 8'h29, 24'h0, 12'h0, 21'h400, 8'hb0},
            '{8'h02, 8'h09, 24'h0, 12'h020, 21'h200, 8'h32}, '{8'h06, 8'h16, 24'h0, 12'h008, 21'h200, 8'h32},
            '{8'h27, 8'h02, 24'h1b411f, 12'h0, 21'h0, 8'hb0}, '{8'h06, 8'h02, 24'h0, 12'h010, 21'h200, 8'h32},
            '{8'h02, 8'h0e, 24'h0, 12'h0, 21'h2, 8'hb0}};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(4'hf, 8'h00);
        wreg(cbl_pkg::A_MIDCH, 8'h41);
        for (i = 0; i < 15; i++) begin
            wreg(cbl_pkg::A_CTRL, rows[i].ctrl);
            issue(rows[i].cmd, 1'b0, 1'b0, cbl_pkg::S_ZERO);
            pulse({9'h000, rows[i].e0});
            for (j = 2; j >= 0; j--) begin
                if (rows[i].ch[j*8+:8] != 8'h00) begin
                    pulse({1'b1, rows[i].ch[j*8+:8], 12'h000});
                end
            end
            pulse(rows[i].e1);
            wait_end(rows[i].es);
            $display("row %0d done", i);
        end
        wreg(cbl_pkg::A_CTRL, 8'h02);
        issue(cbl_pkg::C_READ, 1'b0, 1'b0, cbl_pkg::S_ZERO);
        issue(cbl_pkg::C_POLL, 1'b0, 1'b0, cbl_pkg::S_BUSY);
        issue(cbl_pkg::C_READ, 1'b0, 1'b1, cbl_pkg::S_BUSY);
        sense <= 8'h01;
        pulse(21'h400);
        wait_end(8'h70);
        sense <= 8'h00;
        issue(cbl_pkg::C_READ, 1'b1, 1'b0, cbl_pkg::S_UC);
        issue(8'hff, 1'b0, 1'b0, cbl_pkg::S_UC);
        issue(cbl_pkg::C_READ, 1'b0, 1'b1, cbl_pkg::S_SM);
        pulse(21'h800);
        issue(cbl_pkg::C_WRITE, 1'b0, 1'b0, cbl_pkg::S_ZERO);
        wait_end(8'hb0);
        $display("status tests done");
        wreg(cbl_pkg::A_CTRL, 8'h0a);
        issue(cbl_pkg::C_READ, 1'b0, 1'b0, cbl_pkg::S_ZERO);
        wreg(cbl_pkg::A_ACK, 8'h01);
        for (i = 0; i < 4; i++) begin
            if (i == 3) begin
                rreg(cbl_pkg::A_INFO, 8'h27);
            end
            pulse({1'b1, 8'(8'h41 + i), 12'h000});
        end
        chk({7'h00, ds}, 8'h01);
        rreg(cbl_pkg::A_INFO, 8'h2c);
        wreg(cbl_pkg::A_LCW1, 8'h02);
        rreg(cbl_pkg::A_DATA, 8'h43);
        wreg(cbl_pkg::A_ACK, 8'h01);
        rreg(cbl_pkg::A_INFO, 8'h20);
        pulse(21'h400);
        wait_end(8'h30);
        $display("buffer test done");
        issue(cbl_pkg::C_WRITE, 1'b0, 1'b0, cbl_pkg::S_ZERO);
        evt <= 21'h000001;
        @(posedge clk);
        evt <= '0;
        #1;
        chk({7'h00, tx_valid}, 8'h01);
        chk(tx_char, 8'h41);
        pulse(21'h200);
        wait_end(8'h30);
        $display("transmit test done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rreg(cbl_pkg::A_CTRL, cbl_pkg::CTRL_RST);
        rreg(cbl_pkg::A_MIDCH, cbl_pkg::CH_H);
        rreg(cbl_pkg::A_INFO, 8'h00);
        $display("reset test done");
        summarize();
    end
endmodule
`default_nettype wire
